/* design/sbf_ctrl.sv */
// Supply daughter board control: serial link, set point staging, fault latch
//
// Summary of operation
// R1: Written set point waits in a staging register until a sync arrives.
// R2: Sync leading edge loads the set point converter and starts the reply burst.
// R3: Reply carries both current monitors, voltage, status word, set point, calibration.
// R4: Controller buffers replies, swaps buffer pointers and interrupts its host per sync.
// R5: Bus clear empties fault latch only with no live fault; nothing else changes.
// R6: Clear and inhibit lines filtered on the system clock; held at least 200 ns.
// R7: Asserted inhibit line holds the supply off.
// R8: Reboot line reconfigures the logic only when the enable jumper is fitted.
// R9: Reply bits are shifted out on the reply line, timed by the link clock.
// R10: Command bits are captured from the command line, timed by the link clock.
// R11: Command, sync and link clock lines pass a two-bit digital filter.
// R12: Link clock is synchronised and edge-detected, never used as a clock.
// R13: Controller drives sync, clear, inhibit, reboot, command and link clock lines.
// R14: Missing programming module, filtered 300 ms, raises a fault and shuts down.
// R15: Filter overcurrent, filtered 300 ms, raises a fault and shuts down.
// R16: Fault register bits: protect, bulk on, inhibit, module, filter, heat, out, balance, bus.
// R17: Display shows faults, else shunt current times ten when first mux selects shunt.
// R18: Red fault lamp lights whenever a fault exists.
// R19: Control comes over the backplane link or the serial console.
// R20: Frame is start one, 4-bit command, 32-bit data, odd parity over both.
// R21: Any fault latches and shuts down; later faults add to the latch.
// R22: Starred lines are active low.
// R23: Display and lamp follow the latched fault state within a few cycles.
`timescale 1ns/1ns
module sbf_ctrl #(
    parameter int unsigned FAULT_FILTER = sbf_pkg::FAULT_FILTER_CYCLES,
    // Arbitrary version value
    parameter logic [7:0] VERSION = 8'h5A
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Backplane lines
    input wire logic sync_n,
    input wire logic bus_clear_n,
    input wire logic supply_hold_off_n,
    input wire logic reboot_n,
    input wire logic reboot_jumper,
    input wire logic link_clk,
    input wire logic serial_cmd_n,
    output logic serial_reply_n,
    // Supply status inputs
    input wire logic prog_module_present_n,
    input wire logic filter_overcurrent_n,
    input wire logic heatsink_overtemp,
    input wire logic output_overcurrent,
    input wire logic output_imbalance,
    input wire logic supply_bus_overvoltage,
    input wire logic bulk_supply_on,
    // Converter readings
    input wire logic [23:0] current_monitor_a,
    input wire logic [23:0] current_monitor_b,
    input wire logic [23:0] voltage_monitor,
    // Console command port
    input wire logic console_valid,
    input wire logic [3:0] console_cmd,
    input wire logic [31:0] console_data,
    output logic console_reply_valid,
    output logic [31:0] console_reply_data,
    // Supply and converter control
    output logic [31:0] setpoint_dac,
    output logic setpoint_load,
    output logic [31:0] cal_dac,
    output logic [10:0] mux_ctrl,
    output logic supply_shutdown,
    output logic reconfigure_n,
    // Front panel
    output logic fault_led,
    output logic [sbf_pkg::HEX_W-1:0] hex_display
);
    import sbf_pkg::*;

    logic link_f, cmd_n_f, sync_n_f;
    logic clear_n_f, hold_n_f, reboot_n_f, jumper_f;
    logic bulk_f, present_n_f, filt_n_f, temp_f, output_overcurrent_f, bal_f, ovs_f;
    logic link_q, sync_q, clear_q;
    logic link_rise, link_fall, sync_event, clear_event;
    logic [6:0] live_fault;
    logic [6:0] fault_latch;
    logic [FAULT_W-1:0] fault_status;
    logic [31:0] setpoint_stage;
    sbf_rx_state_t rx_state;
    logic [5:0] rx_left;
    logic [BODY_W:0] rx_sreg;
    logic rx_done;
    logic cmd_valid, cmd_serial;
    sbf_cmd_t cmd_code;
    logic [31:0] cmd_data;
    logic burst_active, single_pending;
    logic [3:0] burst_idx, single_cmd;
    logic tx_busy, tx_load, tx_bit;
    logic [3:0] tx_cmd;
    logic [23:0] shunt_mag;
    logic [32:0] shunt_prod;
    logic [HEX_W-1:0] next_hex;

    // Link lines: two-bit agreement filter, sampled on the system clock
    sbf_deglitch #(.WIDTH(3), .COUNT(LINK_FILTER_CYCLES), .IDLE(3'h3)) u_link_filt (
        .clk(core_clk),
        .reset(reset),
        .pin({link_clk, serial_cmd_n, sync_n}),
        .level({link_f, cmd_n_f, sync_n_f})
    ); // R11 R12

    sbf_deglitch #(.WIDTH(4), .COUNT(LINE_FILTER_CYCLES - 1), .IDLE(4'hE)) u_line_filt (
        .clk(core_clk),
        .reset(reset),
        .pin({bus_clear_n, supply_hold_off_n, reboot_n, reboot_jumper}),
        .level({clear_n_f, hold_n_f, reboot_n_f, jumper_f})
    ); // R6

    sbf_deglitch #(.WIDTH(7), .COUNT(FAULT_FILTER), .IDLE(7'h10)) u_fault_filt (
        .clk(core_clk),
        .reset(reset),
        .pin({bulk_supply_on, prog_module_present_n, filter_overcurrent_n, heatsink_overtemp,
              output_overcurrent, output_imbalance, supply_bus_overvoltage}),
        .level({bulk_f, present_n_f, filt_n_f, temp_f, output_overcurrent_f, bal_f, ovs_f})
    ); // R14 R15

    // Edge detection on filtered levels
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            link_q <= 1'b0;
            sync_q <= 1'b1;
            clear_q <= 1'b1;
        end else begin
            link_q <= link_f;
            sync_q <= sync_n_f;
            clear_q <= clear_n_f;
        end
    end

    assign link_rise = link_f && !link_q; // R12
    assign link_fall = !link_f && link_q; // R12
    assign sync_event = (!sync_n_f && sync_q) || (cmd_valid && cmd_code == CMD_SYNC); // R2 R22
    assign clear_event = (!clear_n_f && clear_q) || (cmd_valid && cmd_code == CMD_CLEAR); // R5

    // Live fault sources in register bit order
    assign live_fault = {!hold_n_f, present_n_f, !filt_n_f, temp_f, output_overcurrent_f, bal_f, ovs_f}; // R16
    assign fault_status = {|fault_latch, bulk_f, fault_latch}; // R16

    // Sticky latch; clear allowed only while nothing is live
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fault_latch <= FAULT_LATCH_RESET;
        end else if (clear_event && live_fault == 7'h00) begin
            fault_latch <= FAULT_LATCH_RESET; // R5
        end else begin
            fault_latch <= fault_latch | live_fault; // R21
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            supply_shutdown <= 1'b1;
            fault_led <= 1'b0;
            reconfigure_n <= 1'b1;
        end else begin
            supply_shutdown <= fault_status[FB_PROTECT] || !hold_n_f; // R7 R21
            fault_led <= fault_status[FB_PROTECT]; // R18 R23
            reconfigure_n <= !(!reboot_n_f && jumper_f); // R8
        end
    end

    // Command capture on link rising edges
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rx_state <= RX_IDLE;
            rx_left <= 6'h00;
            rx_sreg <= '0;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (link_rise) begin
                unique case (rx_state)
                    RX_IDLE: begin
                        if (!cmd_n_f) begin
                            rx_state <= RX_BITS_ST;
                            rx_left <= RX_BITS;
                        end
                    end
                    RX_BITS_ST: begin
                        rx_sreg <= {rx_sreg[BODY_W-1:0], !cmd_n_f}; // R10
                        rx_left <= rx_left - 6'h01;
                        if (rx_left == 6'h01) begin
                            rx_state <= RX_IDLE;
                            rx_done <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // Serial frames with good odd parity win over the console
    always_comb begin
        cmd_serial = rx_done && (^rx_sreg); // R20
        cmd_valid = cmd_serial || console_valid; // R19
        cmd_code = sbf_cmd_t'(cmd_serial ? rx_sreg[BODY_W:DATA_W+1] : console_cmd);
        cmd_data = cmd_serial ? rx_sreg[DATA_W:1] : console_data;
    end

    function automatic logic [31:0] read_word(input logic [3:0] code);
        logic [31:0] w;
        w = WORD_RESET;
        unique case (code)
            CMD_READ_I1: w = {{8{current_monitor_a[23]}}, current_monitor_a};
            CMD_READ_I2: w = {{8{current_monitor_b[23]}}, current_monitor_b};
            CMD_READ_V: w = {{8{voltage_monitor[23]}}, voltage_monitor};
            CMD_READ_CSR: w = {3'h0, VERSION, !clear_n_f, fault_status, mux_ctrl};
            CMD_READ_SP: w = setpoint_stage;
            CMD_READ_CAL: w = cal_dac;
            default: w = WORD_RESET;
        endcase
        return w;
    endfunction

    // Register writes
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            setpoint_stage <= WORD_RESET;
            cal_dac <= WORD_RESET;
            mux_ctrl <= CSR_CTRL_RESET;
        end else if (cmd_valid) begin
            if (cmd_code == CMD_WRITE_SP) begin
                setpoint_stage <= cmd_data; // R1
            end
            if (cmd_code == CMD_WRITE_CAL) begin
                cal_dac <= cmd_data;
            end
            if (cmd_code == CMD_WRITE_CSR) begin
                mux_ctrl <= cmd_data[CSR_CTRL_W-1:0];
            end
        end
    end

    // Converter loads only on sync
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            setpoint_dac <= WORD_RESET;
            setpoint_load <= 1'b0;
        end else begin
            setpoint_load <= sync_event;
            if (sync_event) begin
                setpoint_dac <= setpoint_stage; // R1 R2
            end
        end
    end

    // Console read answers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            console_reply_valid <= 1'b0;
            console_reply_data <= WORD_RESET;
        end else begin
            console_reply_valid <= console_valid && !cmd_serial;
            if (console_valid && !cmd_serial) begin
                console_reply_data <= read_word(console_cmd); // R19
            end
        end
    end

    // Reply scheduling: sync burst of six reads, else a single read answer
    assign tx_load = !tx_busy && (burst_active || single_pending);
    assign tx_cmd = burst_active ? burst_idx : single_cmd;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            burst_active <= 1'b0;
            burst_idx <= 4'h0;
        end else if (sync_event) begin
            burst_active <= 1'b1; // R2
            burst_idx <= CMD_READ_I1;
        end else if (tx_load && burst_active) begin
            burst_idx <= burst_idx + 4'h1; // R3
            if (burst_idx == CMD_READ_CAL) begin
                burst_active <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            single_pending <= 1'b0;
            single_cmd <= 4'h0;
        end else if (cmd_serial && cmd_code >= CMD_READ_I1 && cmd_code <= CMD_READ_CAL) begin
            single_pending <= 1'b1;
            single_cmd <= cmd_code;
        end else if (tx_load && !burst_active) begin
            single_pending <= 1'b0;
        end
    end

    sbf_frame_tx u_tx (
        .core_clk(core_clk),
        .reset(reset),
        .load(tx_load),
        .body({tx_cmd, read_word(tx_cmd)}),
        .busy(tx_busy),
        .shift(link_fall),
        .bit_out(tx_bit)
    ); // R9 R20

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            serial_reply_n <= 1'b1;
        end else begin
            serial_reply_n <= !tx_bit; // R9 R22
        end
    end

    // Display: fault word, else shunt current times ten when the first mux selects shunt, else zero
    always_comb begin
        shunt_mag = current_monitor_a[23] ? 24'(-current_monitor_a) : current_monitor_a;
        shunt_prod = 33'(shunt_mag) * HEX_SCALE_MUL;
        if (fault_status[FB_PROTECT]) begin
            next_hex = HEX_W'(fault_status); // R17
        end else if (mux_ctrl[CSR_I1MUX_LSB+:2] == I1MUX_SHUNT) begin
            next_hex = HEX_W'(shunt_prod >> HEX_SCALE_SHIFT); // R17
        end else begin
            next_hex = '0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hex_display <= '0;
        end else begin
            hex_display <= next_hex; // R23
        end
    end

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence s_sync_seen;
        sync_event ##1 setpoint_load;
    endsequence

    a_stage_hold: assert property (!sync_event |=> $stable(setpoint_dac)) // R1
        else $error("set point changed without sync");
    a_sync_load: assert property (sync_event |=> setpoint_dac == $past(setpoint_stage)) // R2
        else $error("sync did not load staged set point");
    a_burst_start: assert property (s_sync_seen |-> burst_active || tx_busy) // R2
        else $error("sync did not start a reply");
    a_latch_keep: assert property ((|live_fault) |=> !(|($past(fault_latch) & ~fault_latch))) // R5
        else $error("latched fault lost while live");
    a_latch_add: assert property (live_fault[FB_FILTER_OC] |=> fault_latch[FB_FILTER_OC]) // R21
        else $error("live fault not latched");
    a_inhibit_off: assert property (!hold_n_f |=> supply_shutdown) // R7
        else $error("inhibit did not shut supply");
    a_reboot_gate: assert property (!jumper_f |=> reconfigure_n) // R8
        else $error("reboot without jumper");
    a_led_follow: assert property ((|fault_latch) |-> ##[1:2] fault_led) // R18
        else $error("fault lamp not lit");
    a_hex_fault: assert property (fault_status[FB_PROTECT] |=> // R17
        hex_display == HEX_W'($past(fault_status)))
        else $error("display not showing faults");
    a_link_edges: assert property (link_rise |-> !link_fall ##1 !link_rise) // R12
        else $error("link edge detection broken");
endmodule // sbf_ctrl

/* design/sbf_deglitch.sv */
// Three-stage synchroniser with a stable-count filter per bit
`timescale 1ns/1ns
module sbf_deglitch #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned COUNT = 1,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Raw pins and filtered levels
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    localparam int unsigned CW = $clog2(COUNT + 1);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [CW-1:0] cnt [WIDTH];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1 <= IDLE;
            s2 <= IDLE;
            s3 <= IDLE;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Change accepted after stages two and three agree for COUNT cycles
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            level <= IDLE;
            for (int i = 0; i < WIDTH; i++) begin
                cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2[i] == s3[i] && s3[i] != level[i]) begin
                    if (cnt[i] == CW'(COUNT - 1)) begin
                        level[i] <= s3[i];
                        cnt[i] <= '0;
                    end else begin
                        cnt[i] <= cnt[i] + 1'b1;
                    end
                end else begin
                    cnt[i] <= '0;
                end
            end
        end
    end
endmodule // sbf_deglitch

/* design/sbf_frame_tx.sv */
// Reply frame serialiser stepped by detected link clock edges
`timescale 1ns/1ns
module sbf_frame_tx
    import sbf_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Frame load
    input wire logic load,
    input wire logic [sbf_pkg::BODY_W-1:0] body,
    output logic busy,
    // Bit timing and line
    input wire logic shift,
    output logic bit_out
);
    logic [FRAME_BITS-1:0] sreg;
    logic [5:0] left;

    assign busy = (left != 6'h00);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sreg <= '0;
            left <= 6'h00;
            bit_out <= 1'b0;
        end else if (load && !busy) begin
            sreg <= {1'b1, body, ~^body};
            left <= 6'(FRAME_BITS);
        end else if (shift) begin
            bit_out <= busy ? sreg[FRAME_BITS-1] : 1'b0;
            if (busy) begin
                sreg <= {sreg[FRAME_BITS-2:0], 1'b0};
                left <= left - 6'h01;
            end
        end
    end
endmodule // sbf_frame_tx

/* shared/sbf_pkg.sv */
// Constants, field layouts and command codes for the supply backplane fault controller
package sbf_pkg;
    // Clock and timing
    localparam int unsigned CORE_CLK_HZ = 20_000_000;
    localparam int unsigned CORE_PERIOD_NS = 50;
    localparam int unsigned LINE_MIN_NS = 200;
    localparam int unsigned LINE_FILTER_CYCLES =
        (LINE_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int unsigned FAULT_FILTER_MS = 300;
    localparam int unsigned FAULT_FILTER_CYCLES = FAULT_FILTER_MS * (CORE_CLK_HZ / 1000);
    localparam int unsigned LINK_FILTER_CYCLES = 1;

    // Serial frame: start, command, data, odd parity
    localparam int unsigned CMD_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BODY_W = CMD_W + DATA_W;
    localparam int unsigned FRAME_BITS = BODY_W + 2;
    localparam logic [5:0] RX_BITS = 6'h25;

    // Fault register bit positions
    localparam int unsigned FAULT_W = 9;
    localparam int unsigned FB_OVERVOLT = 0;
    localparam int unsigned FB_IMBALANCE = 1;
    localparam int unsigned FB_OUT_OC = 2;
    localparam int unsigned FB_OVERTEMP = 3;
    localparam int unsigned FB_FILTER_OC = 4;
    localparam int unsigned FB_PROG_MISSING = 5;
    localparam int unsigned FB_INHIBIT = 6;
    localparam int unsigned FB_BULK_ON = 7;
    localparam int unsigned FB_PROTECT = 8;
    localparam logic [6:0] FAULT_LATCH_RESET = 7'h00;

    // Control and status word layout
    localparam int unsigned CSR_CTRL_W = 11;
    localparam int unsigned CSR_I1MUX_LSB = 0;
    localparam logic [10:0] CSR_CTRL_RESET = 11'h000;
    localparam logic [1:0] I1MUX_SHUNT = 2'h0;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // Display scaling: amps times ten from the shunt reading
    localparam logic [32:0] HEX_SCALE_MUL = 33'h0_0000_0177;
    localparam int unsigned HEX_SCALE_SHIFT = 23;
    localparam int unsigned HEX_W = 12;

    typedef enum logic [3:0] {
        CMD_RSVD = 4'h0,
        CMD_READ_I1 = 4'h1,
        CMD_READ_I2 = 4'h2,
        CMD_READ_V = 4'h3,
        CMD_READ_CSR = 4'h4,
        CMD_READ_SP = 4'h5,
        CMD_READ_CAL = 4'h6,
        CMD_CLEAR = 4'h7,
        CMD_WRITE_CSR = 4'h8,
        CMD_WRITE_SP = 4'h9,
        CMD_WRITE_CAL = 4'hA,
        CMD_SYNC = 4'hF
    } sbf_cmd_t;

    typedef enum logic {
        RX_IDLE = 1'b0,
        RX_BITS_ST = 1'b1
    } sbf_rx_state_t;
endpackage

/* tb/sbf_link_host.sv */
// Controller board model: link clock, command frames and reply capture
`timescale 1ns/1ns
module sbf_link_host (
    // Link base clock
    input wire logic lclk,
    // Link lines
    output logic link_clk,
    output logic serial_cmd_n,
    input wire logic serial_reply_n,
    // Captured reply frame
    output logic rx_valid,
    output logic [37:0] rx_frame
);
    int rx_cnt = 0;
    initial begin
        link_clk = 1'b0;
        serial_cmd_n = 1'b1;
        rx_valid = 1'b0;
        rx_frame = '0;
    end
    // Launch on the fall, device samples on the rise
    task automatic bit_cycle(input logic b);
        @(posedge lclk);
        rx_valid = 1'b0;
        if (link_clk && (rx_cnt != 0 || !serial_reply_n)) begin
            rx_frame = {rx_frame[36:0], ~serial_reply_n};
            rx_cnt++;
        end
        if (rx_cnt == 38) begin
            rx_valid = 1'b1;
            rx_cnt = 0;
        end
        link_clk = 1'b0;
        serial_cmd_n = ~b;
        repeat (4) @(posedge lclk);
        link_clk = 1'b1;
        repeat (3) @(posedge lclk);
    endtask
    task automatic send(input logic [3:0] cmd, input logic [31:0] data, input logic bad);
        logic [37:0] f;
        f = {1'b1, cmd, data, ~^{cmd, data} ^ bad};
        for (int i = 37; i >= 0; i--) bit_cycle(f[i]);
        bit_cycle(1'b0);
    endtask
    // Clock idle bits so the device can answer
    task automatic idle(input int n);
        repeat (n) bit_cycle(1'b0);
    endtask
endmodule // sbf_link_host

/* tb/test_supply_backplane_fault_ctrl.sv */
// Self-checking bench for the supply backplane fault controller
`timescale 1ns/1ns
module test_supply_backplane_fault_ctrl;
    import sbf_pkg::*;
    localparam logic [7:0] VER = 8'h3C; // Arbitrary version value
    logic core_clk, lclk, reset, sync_n, bus_clear_n, reboot_n, reboot_jumper, bulk_on;
    logic link_clk, serial_cmd_n, serial_reply_n, rx_valid, console_valid, console_reply_valid;
    logic setpoint_load, supply_shutdown, reconfigure_n, fault_led;
    logic [6:0] live, l1, l2;
    logic [3:0] console_cmd;
    logic [31:0] console_data, console_reply_data, setpoint_dac, cal_dac, rng, sp, cal;
    logic [23:0] cur_a, cur_b, volt;
    logic [37:0] rx_frame;
    logic [10:0] mux_ctrl;
    logic [11:0] hex_display;
    logic [37:0] exp_q[$];
    logic [31:0] con_q[$];
    int compares = 0;
    int miscompares = 0;
    int n;
    sbf_ctrl #(.FAULT_FILTER(8), .VERSION(VER)) u_dut (
        .core_clk(core_clk), .reset(reset), .sync_n(sync_n), .bus_clear_n(bus_clear_n),
        .supply_hold_off_n(~live[6]), .reboot_n(reboot_n), .reboot_jumper(reboot_jumper),
        .link_clk(link_clk), .serial_cmd_n(serial_cmd_n), .serial_reply_n(serial_reply_n),
        .prog_module_present_n(live[5]), .filter_overcurrent_n(~live[4]),
        .heatsink_overtemp(live[3]), .output_overcurrent(live[2]), .output_imbalance(live[1]),
        .supply_bus_overvoltage(live[0]), .bulk_supply_on(bulk_on),
        .current_monitor_a(cur_a), .current_monitor_b(cur_b), .voltage_monitor(volt),
        .console_valid(console_valid), .console_cmd(console_cmd), .console_data(console_data),
        .console_reply_valid(console_reply_valid), .console_reply_data(console_reply_data),
        .setpoint_dac(setpoint_dac), .setpoint_load(setpoint_load), .cal_dac(cal_dac),
        .mux_ctrl(mux_ctrl), .supply_shutdown(supply_shutdown), .reconfigure_n(reconfigure_n),
        .fault_led(fault_led), .hex_display(hex_display));
    sbf_link_host u_host (.lclk(lclk), .link_clk(link_clk), .serial_cmd_n(serial_cmd_n),
        .serial_reply_n(serial_reply_n), .rx_valid(rx_valid), .rx_frame(rx_frame));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [37:0] frame(input logic [3:0] c, input logic [31:0] d);
        return {1'b1, c, d, ~^{c, d}};
    endfunction
    function automatic logic [11:0] shunt_x10(input logic [23:0] a);
        logic [32:0] p;
        p = 33'(a[23] ? 24'(-a) : a) * 33'h177;
        return 12'(p >> 23);
    endfunction
    task automatic chk(input string name, input logic [37:0] exp, input logic [37:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic con(input logic [3:0] c, input logic [31:0] d, input logic [31:0] e);
        con_q.push_back(e);
        @(posedge core_clk);
        console_valid <= 1'b1;
        console_cmd <= c;
        console_data <= d;
        @(posedge core_clk);
        console_valid <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic clear_pulse(input int w);
        repeat (15) @(posedge core_clk);
        bus_clear_n <= 1'b0;
        repeat (w) @(posedge core_clk);
        bus_clear_n <= 1'b1;
        repeat (20) @(negedge core_clk);
    endtask
    always @(posedge core_clk)
        if (console_reply_valid === 1'b1)
            chk("console", 38'(con_q.pop_front()), 38'(console_reply_data));
    always @(posedge rx_valid) chk("reply frame", exp_q.pop_front(), rx_frame);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        lclk = 1'b0;
        #13;
        forever #40 lclk = ~lclk;
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        reset = 1'b1;
        sync_n = 1'b1;
        bus_clear_n = 1'b1;
        reboot_n = 1'b1;
        reboot_jumper = 1'b0;
        bulk_on = 1'b1;
        console_valid = 1'b0;
        console_cmd = 4'h0;
        console_data = 32'h0;
        live = 7'h00;
        rng = xs(32'hD9B59AF1);
        cur_a = rng[23:0];
        rng = xs(rng);
        cur_b = rng[23:0];
        rng = xs(rng);
        volt = rng[23:0];
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        repeat (12) @(negedge core_clk);
        chk("shunt display", 38'(shunt_x10(cur_a)), 38'(hex_display));
        chk("shutdown idle", 38'(0), 38'(supply_shutdown));
        rng = xs(rng);
        cal = rng;
        con(CMD_WRITE_CAL, cal, 32'h0);
        u_host.send(CMD_WRITE_CAL, ~cal, 1'b1);
        repeat (20) @(posedge core_clk);
        con(CMD_READ_CAL, 32'h0, cal);
        chk("cal", 38'(cal), 38'(cal_dac));
        rng = xs(rng);
        sp = rng;
        u_host.send(CMD_WRITE_SP, sp, 1'b0);
        repeat (20) @(negedge core_clk);
        chk("staged set point", 38'(0), 38'(setpoint_dac));
        exp_q.push_back(frame(CMD_READ_I1, {{8{cur_a[23]}}, cur_a}));
        exp_q.push_back(frame(CMD_READ_I2, {{8{cur_b[23]}}, cur_b}));
        exp_q.push_back(frame(CMD_READ_V, {{8{volt[23]}}, volt}));
        exp_q.push_back(frame(CMD_READ_CSR, {3'h0, VER, 1'b0, 9'h080, 11'h000}));
        exp_q.push_back(frame(CMD_READ_SP, sp));
        exp_q.push_back(frame(CMD_READ_CAL, cal));
        @(posedge core_clk);
        sync_n <= 1'b0;
        for (n = 0; n < 40 && setpoint_load !== 1'b1; n++) @(negedge core_clk);
        if (n == 40) miscompares++;
        if (n == 40) report_and_stop();
        chk("set point load", 38'(sp), 38'(setpoint_dac));
        @(posedge core_clk);
        sync_n <= 1'b1;
        u_host.idle(250);
        for (int i = 0; i < 7; i++) begin
            l1 = 7'(1 << i);
            l2 = l1 | 7'(1 << ((i + 1) % 7));
            @(posedge core_clk);
            live <= l1;
            repeat (30) @(negedge core_clk);
            chk("shutdown", 38'(1), 38'(supply_shutdown));
            chk("fault lamp", 38'(1), 38'(fault_led));
            @(posedge core_clk);
            live <= l2;
            clear_pulse(6);
            chk("fault display", 38'({5'h03, l2}), 38'(hex_display));
            @(posedge core_clk);
            live <= 7'h00;
            clear_pulse(2);
            chk("held fault", 38'({5'h03, l2}), 38'(hex_display));
            clear_pulse(4);
            chk("cleared lamp", 38'(0), 38'(fault_led));
            chk("cleared display", 38'(shunt_x10(cur_a)), 38'(hex_display));
        end
        for (int j = 0; j < 2; j++) begin
            @(posedge core_clk);
            reboot_jumper <= j[0];
            reboot_n <= 1'b0;
            repeat (15) @(negedge core_clk);
            chk("reconfigure", 38'(j == 0), 38'(reconfigure_n));
            @(posedge core_clk);
            reboot_n <= 1'b1;
            repeat (15) @(posedge core_clk);
        end
        con(CMD_WRITE_CSR, 32'h7FF, 32'h0);
        chk("mux", 38'h7FF, 38'(mux_ctrl));
        chk("replies left", 38'(0), 38'(exp_q.size()));
        report_and_stop();
    end
endmodule // test_supply_backplane_fault_ctrl
